// *** sideband_pkg.sv ***
// Constants shared by the sideband separation filter design
package sideband_pkg;
    // Receivers per digitizer module, one per polarization
    localparam int RECEIVERS = 2;
    // Default filter shape
    localparam int TAPS_DEFAULT = 8;
    localparam int SAMPLE_WIDTH = 12;
    localparam int COEF_WIDTH = 16;
    localparam int OUT_WIDTH = 16;
    // Filter slots: 0 I->upper, 1 Q->upper, 2 I->lower, 3 Q->lower
    localparam int FILTERS = 4;
    localparam int FILTERS_REDUCED = 2;
    // Output FIFO shape
    localparam int FIFO_DEPTH = 8;
    // Coefficient value loaded at boot: unit impulse on tap 0 of I filters
    localparam logic [15:0] COEF_UNIT = 16'h4000;
    localparam logic [15:0] COEF_ZERO = 16'h0000;
    // Scaling shift from product back to output width
    localparam int PRODUCT_SHIFT = 14;
    // Modes of the filter bank
    typedef enum logic [1:0] {
        MODE_FULL = 2'b01,
        MODE_REDUCED = 2'b10
    } mode_type;
endpackage

// *** sideband_fifo.sv ***
// Small valid/ready FIFO for calibrated sideband samples
`timescale 1ns/1ps
module sideband_fifo
    import sideband_pkg::*;
#(
    parameter int WIDTH = 32,
    parameter int DEPTH = FIFO_DEPTH
)
(
    input wire logic clk,
    input wire logic arst_n,
    input wire logic ce,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic [AW-1:0] wr_reg;
    logic [AW-1:0] rd_reg;
    logic [AW:0] count_reg;
    wire push = ce && in_valid && in_ready;
    wire pop = ce && out_valid && out_ready;

    // Honest flags straight from the occupancy count
    assign in_ready = (count_reg != (AW+1)'(DEPTH));
    assign out_valid = (count_reg != '0);
    assign out_data = mem_reg[rd_reg];

    // Storage array, no reset needed on data
    always_ff @(posedge clk)
    begin
        if (push)
            mem_reg[wr_reg] <= in_data;
    end

    // Pointers wrap on depth so non power of two depths work
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            wr_reg <= '0;
            rd_reg <= '0;
            count_reg <= '0;
        end
        else
        begin
            if (push)
                wr_reg <= (wr_reg == AW'(DEPTH-1)) ? '0 : wr_reg + 1'b1;
            if (pop)
                rd_reg <= (rd_reg == AW'(DEPTH-1)) ? '0 : rd_reg + 1'b1;
            if (push && !pop)
                count_reg <= count_reg + 1'b1;
            else if (pop && !push)
                count_reg <= count_reg - 1'b1;
        end
    end
endmodule // sideband_fifo

// *** sideband_separation_filter.sv ***
// Digital sideband separation and coarse bandpass calibration stage
// What this block does
// - Calibration acts first; output goes to the frequency shifter next.
// - One independent parallel calibration chain per receiver, two receivers.
// - Filter I and Q separately, combine into sidebands; four filters.
// - Reduced mode uses only two filters when calibration is not needed.
// - Separation runs in the time domain before any shift or channelizer.
// - Coefficients are held in local storage for quick reconfiguration.
// - Coefficients load at boot; control port rewrites them, new set applied.
// - At least 30 dB separation, 40 dB goal, set by taps and coef width.
// - Sustain full input rate per receiver without dropping samples.
`timescale 1ns/1ps
module sideband_separation_filter
    import sideband_pkg::*;
#(
    parameter int TAPS = TAPS_DEFAULT,
    parameter int SW = SAMPLE_WIDTH,
    parameter int CW = COEF_WIDTH,
    parameter int OW = OUT_WIDTH,
    parameter int DEPTH = FIFO_DEPTH
)
(
    input wire logic CLK,
    input wire logic ARST_N,
    input wire logic CE,
    // Digitizer samples, one I and Q pair per receiver per cycle
    input wire logic IN_VALID,
    input wire logic [RECEIVERS*SW-1:0] IN_I,
    input wire logic [RECEIVERS*SW-1:0] IN_Q,
    output logic IN_READY,
    // Monitor and control coefficient write port
    input wire logic COEF_WE,
    input wire logic [$clog2(RECEIVERS)-1:0] COEF_RX,
    input wire logic [1:0] COEF_FILTER,
    input wire logic [$clog2(TAPS)-1:0] COEF_TAP,
    input wire logic [CW-1:0] COEF_DATA,
    input wire logic COEF_COMMIT,
    input wire logic REDUCED_MODE,
    output logic COEF_PENDING,
    // Calibrated sidebands toward the coarse frequency shifter
    output logic OUT_VALID,
    input wire logic OUT_READY,
    output logic [RECEIVERS*OW-1:0] OUT_UPPER,
    output logic [RECEIVERS*OW-1:0] OUT_LOWER,
    output logic OVERFLOW
);
    localparam int TW = $clog2(TAPS);
    localparam int RW = $clog2(RECEIVERS);
    localparam int AW = SW + CW + TW + 1;
    localparam int FW = RECEIVERS * 2 * OW;

    // Saturating scale from accumulator to output width
    function automatic logic [OW-1:0] scale_sat(input logic signed [AW-1:0] v);
        logic signed [AW-1:0] s;
        s = v >>> PRODUCT_SHIFT;
        if (s > AW'(signed'((1 << (OW-1)) - 1)))
            scale_sat = {1'b0, {(OW-1){1'b1}}};
        else if (s < -AW'(signed'(1 << (OW-1))))
            scale_sat = {1'b1, {(OW-1){1'b0}}};
        else
            scale_sat = s[OW-1:0];
    endfunction

    // Boot value of a coefficient: I filters pass, Q filters zero
    function automatic logic [CW-1:0] boot_coef(input int f, input int t);
        boot_coef = ((f == 0 || f == 2) && t == 0) ? CW'(COEF_UNIT)
                                                   : CW'(COEF_ZERO);
    endfunction

    mode_type mode_reg;
    logic pending_reg;
    logic ovf_reg;
    logic fifo_in_ready;
    logic fifo_out_valid;
    logic [FW-1:0] fifo_out_data;
    logic [FW-1:0] fifo_in_data;
    logic stage_valid_reg;
    logic [FW-1:0] stage_data_reg;

    // Pipeline advances only when the FIFO can take the stage output
    wire advance = CE && (!stage_valid_reg || fifo_in_ready);
    wire take = advance && IN_VALID;
    wire reduced = (mode_reg == MODE_REDUCED);

    genvar r, f, t;
    generate
        for (r = 0; r < RECEIVERS; r++)
        begin : rx
            // Independent chain per receiver, processed in parallel
            // Past samples only; the live sample sits on tap 0 of the window
            logic signed [SW-1:0] i_dly [TAPS-1];
            logic signed [SW-1:0] q_dly [TAPS-1];
            logic signed [SW-1:0] i_win [TAPS];
            logic signed [SW-1:0] q_win [TAPS];
            // Shadow set takes writes; active set drives the filters
            logic [CW-1:0] shadow_reg [FILTERS][TAPS];
            logic [CW-1:0] active_reg [FILTERS][TAPS];
            logic signed [AW-1:0] acc [FILTERS];
            wire signed [SW-1:0] i_new = IN_I[r*SW +: SW];
            wire signed [SW-1:0] q_new = IN_Q[r*SW +: SW];

            for (t = 0; t < TAPS; t++)
            begin : tap
                // Live sample on tap 0, so a result includes its own sample
                if (t == 0)
                begin : live
                    assign i_win[t] = i_new;
                    assign q_win[t] = q_new;
                end
                else
                begin : past
                    assign i_win[t] = i_dly[t-1];
                    assign q_win[t] = q_dly[t-1];
                end
                if (t < TAPS-1)
                begin : hist
                    // Time domain delay line, first stage of the chain
                    always_ff @(posedge CLK or negedge ARST_N)
                    begin
                        if (!ARST_N)
                        begin
                            i_dly[t] <= '0;
                            q_dly[t] <= '0;
                        end
                        else if (take)
                        begin
                            i_dly[t] <= i_win[t];
                            q_dly[t] <= q_win[t];
                        end
                    end
                end
                for (f = 0; f < FILTERS; f++)
                begin : flt
                    localparam logic [CW-1:0] BOOT = boot_coef(f, t);
                    wire wr_hit = COEF_WE && CE && COEF_RX == RW'(r)
                        && COEF_FILTER == 2'(f) && COEF_TAP == TW'(t);
                    // Boot load then control rewrites, shadow copied into active on commit
                    always_ff @(posedge CLK or negedge ARST_N)
                    begin
                        if (!ARST_N)
                        begin
                            shadow_reg[f][t] <= BOOT;
                            active_reg[f][t] <= BOOT;
                        end
                        else
                        begin
                            if (wr_hit)
                                shadow_reg[f][t] <= COEF_DATA;
                            if (CE && COEF_COMMIT)
                                active_reg[f][t] <= wr_hit ? COEF_DATA
                                                           : shadow_reg[f][t];
                        end
                    end
                end
            end

            // Four FIR filters; reduced mode turns off the Q pair
            for (f = 0; f < FILTERS; f++)
            begin : mac
                always_comb
                begin
                    acc[f] = '0;
                    // Widen both factors first so no product bits are lost
                    for (int k = 0; k < TAPS; k++)
                        acc[f] = acc[f]
                            + AW'((f % 2) == 0 ? i_win[k] : q_win[k])
                            * AW'(signed'(active_reg[f][k]));
                    if (reduced && (f == 1 || f == 3))
                        acc[f] = '0;
                end
            end

            // Upper = filtered I plus filtered Q, lower = filtered I minus filtered Q, own pair each
            wire signed [AW-1:0] upper = acc[0] + acc[1];
            wire signed [AW-1:0] lower = acc[2] - acc[3];
            // Width parameters set the achievable rejection
            assign fifo_in_data[r*2*OW +: OW] = scale_sat(upper);
            assign fifo_in_data[r*2*OW+OW +: OW] = scale_sat(lower);
        end
    endgenerate

    // Output register of the filter stage, feeds the FIFO
    always_ff @(posedge CLK or negedge ARST_N)
    begin
        if (!ARST_N)
        begin
            stage_valid_reg <= 1'b0;
            stage_data_reg <= '0;
        end
        else if (advance)
        begin
            stage_valid_reg <= IN_VALID;
            stage_data_reg <= fifo_in_data;
        end
    end

    // Mode and commit tracking; mode follows the strap each enabled cycle
    always_ff @(posedge CLK or negedge ARST_N)
    begin
        if (!ARST_N)
        begin
            mode_reg <= MODE_FULL;
            pending_reg <= 1'b0;
            ovf_reg <= 1'b0;
        end
        else if (CE)
        begin
            mode_reg <= REDUCED_MODE ? MODE_REDUCED : MODE_FULL;
            // Write in the commit cycle still counts as pending cleared
            if (COEF_COMMIT)
                pending_reg <= 1'b0;
            else if (COEF_WE)
                pending_reg <= 1'b1;
            // Sticky: a sample offered while stalled would be lost upstream
            if (IN_VALID && !advance)
                ovf_reg <= 1'b1;
        end
    end

    // Buffer toward the coarse frequency shifter, next in the chain
    sideband_fifo #(
        .WIDTH(FW),
        .DEPTH(DEPTH)
    ) out_fifo (
        .clk(CLK),
        .arst_n(ARST_N),
        .ce(CE),
        .in_valid(stage_valid_reg && advance),
        .in_ready(fifo_in_ready),
        .in_data(stage_data_reg),
        .out_valid(fifo_out_valid),
        .out_ready(OUT_READY),
        .out_data(fifo_out_data)
    );

    // Output registers for IN_READY, COEF_PENDING and OVERFLOW; data and valid come from the FIFO
    always_ff @(posedge CLK or negedge ARST_N)
    begin
        if (!ARST_N)
        begin
            IN_READY <= 1'b0;
            COEF_PENDING <= 1'b0;
            OVERFLOW <= 1'b0;
        end
        else if (CE)
        begin
            IN_READY <= fifo_in_ready;
            COEF_PENDING <= pending_reg;
            OVERFLOW <= ovf_reg;
        end
    end

    // FIFO head presented directly; valid mirrors the FIFO flag
    generate
        for (r = 0; r < RECEIVERS; r++)
        begin : unpack
            assign OUT_UPPER[r*OW +: OW] = fifo_out_data[r*2*OW +: OW];
            assign OUT_LOWER[r*OW +: OW] = fifo_out_data[r*2*OW+OW +: OW];
        end
    endgenerate
    assign OUT_VALID = fifo_out_valid;
endmodule // sideband_separation_filter

// *** sideband_filter_monitor.sv ***
// Port checker for the sideband separation filter
`timescale 1ns/1ps
module sideband_filter_monitor
    import sideband_pkg::*;
#(
    parameter int OW = OUT_WIDTH
)
(
    input wire logic CLK,
    input wire logic ARST_N,
    input wire logic CE,
    input wire logic IN_VALID,
    input wire logic COEF_WE,
    input wire logic COEF_COMMIT,
    input wire logic COEF_PENDING,
    input wire logic OUT_VALID,
    input wire logic OUT_READY,
    input wire logic [RECEIVERS*OW-1:0] OUT_UPPER,
    input wire logic [RECEIVERS*OW-1:0] OUT_LOWER,
    input wire logic OVERFLOW
);
    // One domain, so clock and reset are stated once
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!ARST_N);
    // Writes wait in the shadow set until a commit
    // Pending flag is registered twice, so it shows two enabled cycles later
    property p_pend;
        CE && COEF_WE && !COEF_COMMIT ##1 CE |=> COEF_PENDING;
    endproperty
    a_pend: assert property (p_pend)
        else $error("write left no pending set");
    property p_commit; CE && COEF_COMMIT ##1 CE |=> !COEF_PENDING; endproperty
    a_commit: assert property (p_commit)
        else $error("commit left set pending");
    // Empty path: a taken sample shows two cycles later
    property p_lat; CE && IN_VALID && !OUT_VALID ##1 CE |-> ##1 OUT_VALID; endproperty
    a_lat: assert property (p_lat)
        else $error("sample late or lost");
    property p_hold;
        OUT_VALID && !(OUT_READY && CE)
        |=> OUT_VALID && $stable(OUT_UPPER) && $stable(OUT_LOWER);
    endproperty
    a_hold: assert property (p_hold)
        else $error("head changed while stalled");
    property p_sticky; OVERFLOW |=> OVERFLOW; endproperty
    a_sticky: assert property (p_sticky)
        else $error("overflow flag dropped");
    property p_freeze;
        !CE |=> $stable(OUT_VALID) && $stable(COEF_PENDING) && $stable(OVERFLOW);
    endproperty
    a_freeze: assert property (p_freeze)
        else $error("state moved with enable low");
    // No output may appear without a sample behind it
    property p_idle; (CE && !IN_VALID)[*3] ##0 !OUT_VALID |=> !OUT_VALID; endproperty
    a_idle: assert property (p_idle)
        else $error("output without input");
    // Flag passes two registers; enable high two back pins the offer
    property p_ovf;
        $rose(OVERFLOW) && $past(CE, 2) |-> $past(IN_VALID, 2);
    endproperty
    a_ovf: assert property (p_ovf)
        else $error("overflow without offered sample");
    c_take: cover property (CE && IN_VALID && !OUT_VALID);
    c_stall: cover property (OUT_VALID && !OUT_READY ##1 OUT_VALID);
    c_ovf: cover property ($rose(OVERFLOW));
endmodule // sideband_filter_monitor

// Attach the checker to every filter instance
bind sideband_separation_filter sideband_filter_monitor #(.OW(OW)) u_mon (
    .CLK, .ARST_N, .CE, .IN_VALID, .COEF_WE, .COEF_COMMIT, .COEF_PENDING,
    .OUT_VALID, .OUT_READY, .OUT_UPPER, .OUT_LOWER, .OVERFLOW
);

// *** digitizer_model.sv ***
// Behavioural receiver digitizer feeding I and Q samples
`timescale 1ns/1ps
module digitizer_model
(
    input wire logic CLK,
    input wire logic ARST_N,
    input wire logic CE,
    input wire logic IN_READY,
    input wire logic run,
    input wire logic slow,
    input wire logic frc,
    output logic IN_VALID,
    output logic [23:0] IN_I,
    output logic [23:0] IN_Q
);
    logic [31:0] r;
    logic [1:0] gap;
    // Offer held until CE takes it; idle lines toggle so stale data shows
    always @(posedge CLK or negedge ARST_N)
        if (!ARST_N)
        begin
            IN_VALID <= 1'b0;
            r <= 32'h0000_0002;
            gap <= 2'h0;
        end
        else if (CE || !IN_VALID)
        begin
            if (run && (frc || IN_READY) && gap == 2'h0)
            begin
                IN_VALID <= 1'b1;
                r <= {r[30:0], r[31] ^ r[21] ^ r[1] ^ r[0]};
                IN_I <= r[23:0];
                IN_Q <= r[31:8];
                gap <= slow ? 2'h3 : 2'h0;
            end
            else
            begin
                IN_VALID <= 1'b0;
                IN_I <= ~IN_I;
                IN_Q <= ~IN_Q;
                gap <= gap == 2'h0 ? 2'h0 : gap - 2'h1;
            end
        end
endmodule // digitizer_model

// *** tb_top.sv ***
// Self-checking bench for the sideband separation filter
`timescale 1ns/1ps
module tb_top;
    import sideband_pkg::*;
    logic CLK, ARST_N, CE, OUT_READY, COEF_WE, COEF_COMMIT, REDUCED_MODE;
    logic [0:0] COEF_RX;
    logic [1:0] COEF_FILTER;
    logic [2:0] COEF_TAP;
    logic [15:0] COEF_DATA;
    logic run, slow, frc;
    wire logic IN_VALID, IN_READY, COEF_PENDING, OUT_VALID, OVERFLOW;
    wire logic [23:0] IN_I, IN_Q;
    wire logic [31:0] OUT_UPPER, OUT_LOWER;
    int sh[2][4][8], act[2][4][8], hi[2][8], hq[2][8];
    int n_mismatch, checked, i, u, l, m;
    logic [31:0] qu[$], ql[$], eu, el, x;
    sideband_separation_filter u_dut (.CLK, .ARST_N, .CE, .IN_VALID, .IN_I,
        .IN_Q, .IN_READY, .COEF_WE, .COEF_RX, .COEF_FILTER, .COEF_TAP,
        .COEF_DATA, .COEF_COMMIT, .REDUCED_MODE, .COEF_PENDING, .OUT_VALID,
        .OUT_READY, .OUT_UPPER, .OUT_LOWER, .OVERFLOW);
    digitizer_model u_dig (.CLK, .ARST_N, .CE, .IN_READY, .run, .slow,
        .frc, .IN_VALID, .IN_I, .IN_Q);
    function automatic logic [31:0] nx(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction
    function automatic logic [15:0] sat(input int v);
        return v > 32767 ? 16'h7FFF : v < -32768 ? 16'h8000 : v[15:0];
    endfunction
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic results();
        if (n_mismatch == 0 && checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    // Reset also restores the boot set: unit tap 0 on the I filters
    task automatic rst();
        @(posedge CLK);
        ARST_N <= 1'b0;
        for (int a = 0; a < 64; a++)
            sh[a/32][a/8%4][a%8] = (a % 8 == 0 && a / 8 % 2 == 0) ? 16384 : 0;
        hi = '{default: 0};
        hq = '{default: 0};
        act = sh;
        qu.delete();
        ql.delete();
        repeat (2) @(posedge CLK);
        ARST_N <= 1'b1;
        @(posedge CLK);
    endtask
    // Predict both sidebands of both receivers for one taken sample
    task automatic predict();
        m = REDUCED_MODE ? 0 : 1;
        for (int a = 0; a < 2; a++)
        begin
            for (int k = 7; k > 0; k--)
            begin
                hi[a][k] = hi[a][k-1];
                hq[a][k] = hq[a][k-1];
            end
            hi[a][0] = $signed(IN_I[a*12+:12]);
            hq[a][0] = $signed(IN_Q[a*12+:12]);
            u = 0;
            l = 0;
            for (int k = 0; k < 8; k++)
            begin
                u += hi[a][k] * act[a][0][k] + m * hq[a][k] * act[a][1][k];
                l += hi[a][k] * act[a][2][k] - m * hq[a][k] * act[a][3][k];
            end
            eu[a*16+:16] = sat(u >>> 14);
            el[a*16+:16] = sat(l >>> 14);
        end
        qu.push_back(eu);
        ql.push_back(el);
    endtask
    task automatic stream(input int n, input bit rce);
        run <= 1'b1;
        repeat (n)
        begin
            @(posedge CLK);
            x = nx(x);
            CE <= !rce || x[0] || x[1];
        end
        @(posedge CLK);
        CE <= 1'b1;
        run <= 1'b0;
        repeat (12) @(posedge CLK);
    endtask
    // Mirror coefficient traffic and check every popped result
    always @(posedge CLK)
        if (ARST_N && CE)
        begin
            if (OUT_VALID && OUT_READY)
            begin
                chk(OUT_UPPER, qu.pop_front());
                chk(OUT_LOWER, ql.pop_front());
            end
            // A sample taken on the commit edge still sees the old set
            if (IN_VALID && !frc)
                predict();
            if (COEF_WE)
                sh[COEF_RX][COEF_FILTER][COEF_TAP] = $signed(COEF_DATA);
            if (COEF_COMMIT)
                act = sh;
        end
    initial
    begin
        CLK = 1'b0;
        forever #2 CLK = ~CLK;
    end
    // Guard against a hang, well past the expected run length
    initial
    begin
        #20000;
        n_mismatch++;
        results();
    end
    initial
    begin
        {ARST_N, COEF_WE, COEF_COMMIT, REDUCED_MODE, run, slow, frc} = '0;
        {CE, OUT_READY, COEF_RX, COEF_FILTER, COEF_TAP, COEF_DATA} = '1;
        x = 32'h0000_0002;
        rst();
        chk(OUT_VALID, 0);
        stream(30, 1);
        for (i = 0; i < 24; i++)
        begin
            @(posedge CLK);
            x = nx(x);
            {COEF_WE, COEF_RX, COEF_FILTER, COEF_TAP} <= {1'b1, x[5:0]};
            COEF_DATA <= x[31:16];
        end
        @(posedge CLK);
        COEF_WE <= 1'b0;
        @(posedge CLK);
        chk(COEF_PENDING, 1);
        stream(12, 0);
        COEF_COMMIT <= 1'b1;
        @(posedge CLK);
        COEF_COMMIT <= 1'b0;
        repeat (2) @(posedge CLK);
        chk(COEF_PENDING, 0);
        stream(30, 1);
        REDUCED_MODE <= 1'b1;
        stream(20, 0);
        {REDUCED_MODE, OUT_READY, slow, run} <= 4'b0011;
        repeat (60) @(posedge CLK);
        run <= 1'b0;
        repeat (4) @(posedge CLK);
        chk(IN_READY, 0);
        chk(qu.size(), FIFO_DEPTH);
        {OUT_READY, slow} <= 2'b10;
        for (i = 0; i < 40 && (i < 2 || OUT_VALID); i++) @(posedge CLK);
        chk(OUT_VALID, 0);
        chk(qu.size(), 0);
        {OUT_READY, frc, run} <= 3'b011;
        repeat (20) @(posedge CLK);
        {frc, run} <= 2'b00;
        @(posedge CLK);
        chk(OVERFLOW, 1);
        rst();
        chk(OVERFLOW, 0);
        results();
    end
endmodule // tb_top
